// >>> hdl/uhie_defs.svh
// Contract
// RQ1: Interrupt asserts when any enabled status source is active.
// RQ2: Status flags set regardless of their enable bits.
// RQ3: Async-advance enable bit 5 interrupts at next threshold.
// RQ4: System-error enable bit 4 interrupts immediately.
// RQ5: Rollover enable bit 3 interrupts immediately.
// RQ6: Port-change enable bit 2 interrupts immediately.
// RQ7: Transaction-error enable bit 1 interrupts at next threshold.
// RQ8: Transfer-done enable bit 0 interrupts at next threshold.
// RQ9: Software writes reserved bits as zero.
// RQ10: Frame index advances every 125 us while running.
// RQ11: Frame index is 14 bits, incremented each microframe.
// RQ12: Start-of-frame number is frame index bits 13 to 3.
// RQ13: List index is bits N to 3; eight microframes per entry.
// RQ14: List size 00b N=12, 01b N=11, 10b N=10, 11b reserved.
// RQ15: Software writes frame index only as full 32-bit access.
// RQ16: Frame index writes accepted only while halted flag set.
// RQ17: Software avoids frame index writes while run control set.
// RQ18: Accepted frame index write changes subsequent frame number.
// RQ19: Rollover flag set whenever the list index wraps to zero.
// RQ20: Frame index wraps from maximum to zero and continues.
`ifndef UHIE_DEFS_SVH
`define UHIE_DEFS_SVH

`define UHIE_OFS_INTR_EN 8'h28
`define UHIE_OFS_MICROFRAME_INDEX 8'h2C
`define UHIE_SRC_W 6
`define UHIE_IDX_W 14
`define UHIE_EN_MASK 32'h0000003F
`define UHIE_IDX_MASK 32'h00003FFF
`define UHIE_BIT_XFER 0
`define UHIE_BIT_XERR 1
`define UHIE_BIT_PORT 2
`define UHIE_BIT_ROLL 3
`define UHIE_BIT_SERR 4
`define UHIE_BIT_ASYNC 5
`define UHIE_THRESH_SRC 6'h23
`define UHIE_LS_1024 2'h0
`define UHIE_LS_512 2'h1
`define UHIE_LS_256 2'h2
`define UHIE_SOF_LSB 3
`define UHIE_UFRAME_NS 125000
`define UHIE_CLK_NS 10
`define UHIE_UFRAME_CYC (`UHIE_UFRAME_NS / `UHIE_CLK_NS)

`endif

// >>> hdl/uhie_pkg.sv
package uhie_pkg;
  typedef enum logic [1:0] {
    UHIE_LS_SZ_1024 = 2'h0,
    UHIE_LS_SZ_512 = 2'h1,
    UHIE_LS_SZ_256 = 2'h2,
    UHIE_LS_SZ_RSVD = 2'h3
  } uhie_list_size_t;
endpackage

// >>> hdl/uhie_uframe_tick.sv
`timescale 1ns/1ps
`default_nettype none
`include "uhie_defs.svh"
module uhie_uframe_tick #(
  parameter int unsigned CYCLES = `UHIE_UFRAME_CYC
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic run_i,
  output logic tick_o
);
  logic [31:0] cnt_reg;
  logic [31:0] cnt_next;
  wire last_w = (cnt_reg == 32'(CYCLES - 1));

  // Restart while stopped so the first microframe is full length
  assign cnt_next = !run_i ? 32'h00000000 :
                    last_w ? 32'h00000000 : cnt_reg + 32'h00000001;
  assign tick_o = run_i && last_w;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_reg <= 32'h00000000;
    end else begin
      cnt_reg <= cnt_next;
    end
  end
endmodule
`default_nettype wire

// >>> hdl/uhie_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "uhie_defs.svh"
module uhie_regs #(
  parameter int unsigned UFRAME_CYCLES = `UHIE_UFRAME_CYC
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [31:0] reg_wdata_i,
  output logic [31:0] reg_rdata_o,
  input wire logic run_control_i,
  input wire logic halted_flag_i,
  input wire logic [1:0] list_size_select_i,
  input wire logic threshold_i,
  input wire logic [5:0] status_flags_i,
  output logic rollover_set_o,
  output logic irq_o,
  output logic [13:0] microframe_index_o,
  output logic [10:0] sof_frame_number_o,
  output logic [9:0] list_index_o
);
  logic [`UHIE_SRC_W-1:0] intr_en_reg;
  logic [`UHIE_IDX_W-1:0] index_reg;
  logic [`UHIE_IDX_W-1:0] index_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic irq_reg;
  logic rollover_reg;
  logic rollover_next;
  logic tick_w;

  uhie_uframe_tick #(
    .CYCLES(UFRAME_CYCLES)
  ) u_tick (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .run_i(run_control_i),
    .tick_o(tick_w)
  );

  wire sel_en_w = (reg_addr_i == `UHIE_OFS_INTR_EN);
  wire sel_idx_w = (reg_addr_i == `UHIE_OFS_MICROFRAME_INDEX);
  wire wr_en_w = reg_wr_i && sel_en_w;
  // RQ16 halted gate
  wire wr_idx_w = reg_wr_i && sel_idx_w && halted_flag_i;

  // RQ10 RQ11 RQ20 counting
  wire [`UHIE_IDX_W-1:0] inc_w = index_reg + 14'h0001;

  // RQ18 write loads counter
  assign index_next = wr_idx_w ?
                      reg_wdata_i[`UHIE_IDX_W-1:0] :
                      (tick_w ? inc_w : index_reg);

  // RQ14 wrap bit select
  logic wrap_bit_w;
  always_comb begin
    case (uhie_pkg::uhie_list_size_t'(list_size_select_i))
      uhie_pkg::UHIE_LS_SZ_1024: wrap_bit_w = index_reg[13] != inc_w[13];
      uhie_pkg::UHIE_LS_SZ_512: wrap_bit_w = index_reg[12] != inc_w[12];
      uhie_pkg::UHIE_LS_SZ_256: wrap_bit_w = index_reg[11] != inc_w[11];
      default: wrap_bit_w = 1'b0;
    endcase
  end

  // RQ19 rollover pulse
  assign rollover_next = tick_w && wrap_bit_w && !wr_idx_w;
  assign rollover_set_o = rollover_reg;

  // RQ12 frame number
  assign sof_frame_number_o = index_reg[13:`UHIE_SOF_LSB];
  assign microframe_index_o = index_reg;

  // RQ13 RQ14 list index
  assign list_index_o =
    (list_size_select_i == `UHIE_LS_1024) ? index_reg[12:3] :
    (list_size_select_i == `UHIE_LS_512) ? {1'b0, index_reg[11:3]} :
    (list_size_select_i == `UHIE_LS_256) ? {2'b00, index_reg[10:3]} :
    10'h000;

  // RQ1 RQ3 RQ7 RQ8 threshold-gated sources
  wire [5:0] active_w = status_flags_i & intr_en_reg;
  wire thr_pend_w = |(active_w & `UHIE_THRESH_SRC);
  // RQ4 RQ5 RQ6 immediate sources
  wire now_pend_w = |(active_w & ~`UHIE_THRESH_SRC);
  // RQ2 flags stay pollable
  wire irq_next_w = now_pend_w || (thr_pend_w && (threshold_i || irq_reg));
  assign irq_o = irq_reg;

  assign rdata_next =
    sel_en_w ? (32'(intr_en_reg) & `UHIE_EN_MASK) :
    sel_idx_w ? (32'(index_reg) & `UHIE_IDX_MASK) : 32'h00000000;
  assign reg_rdata_o = rdata_reg;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      intr_en_reg <= 6'h00;
      index_reg <= 14'h0000;
      irq_reg <= 1'b0;
      rollover_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
    end else begin
      if (wr_en_w) begin
        intr_en_reg <= reg_wdata_i[`UHIE_SRC_W-1:0];
      end
      index_reg <= index_next;
      irq_reg <= irq_next_w;
      rollover_reg <= rollover_next;
      if (reg_rd_i) begin
        rdata_reg <= rdata_next;
      end
    end
  end
endmodule
`default_nettype wire

// >>> testbench/uhie_regs_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module uhie_regs_assertions (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic run_control_i,
  input wire logic halted_flag_i,
  input wire logic [1:0] list_size_select_i,
  input wire logic [5:0] status_flags_i,
  input wire logic rollover_set_o,
  input wire logic irq_o,
  input wire logic [13:0] microframe_index_o,
  input wire logic [10:0] sof_frame_number_o,
  input wire logic [9:0] list_index_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  wire logic ixw = reg_wr_i && reg_addr_i == 8'h2C;
  wire logic [13:0] ix = microframe_index_o;
  property p_wr; ixw && halted_flag_i |=> ix == $past(reg_wdata_i[13:0]);
  endproperty
  a_wr: assert property (p_wr) else $error("index write lost");
  property p_hold; ixw && !halted_flag_i && !run_control_i |=> $stable(ix);
  endproperty
  a_hold: assert property (p_hold) else $error("write not ignored");
  property p_stop; !run_control_i && !$past(run_control_i) && !ixw
    |=> $stable(ix); endproperty
  a_stop: assert property (p_stop) else $error("index moved idle");
  property p_inc; $changed(ix) && !$past(ixw) |-> ix == $past(ix) + 14'h1;
  endproperty
  a_inc: assert property (p_inc) else $error("bad increment");
  property p_sof; sof_frame_number_o == ix[13:3]; endproperty
  a_sof: assert property (p_sof) else $error("bad frame number");
  property p_list; list_size_select_i == 2'h0 |-> list_index_o == ix[12:3];
  endproperty
  a_list: assert property (p_list) else $error("bad list index");
  property p_roll; list_size_select_i == 2'h0 && $changed(ix[13])
    && !$past(ixw) |-> ##[0:1] rollover_set_o; endproperty
  a_roll: assert property (p_roll) else $error("no rollover");
  property p_irq; status_flags_i == 6'h00 |=> !irq_o; endproperty
  a_irq: assert property (p_irq) else $error("irq without source");
endmodule
`default_nettype wire

// >>> testbench/usb_host_irq_enable_frame_index_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module usb_host_irq_enable_frame_index_tb_top;
  logic clk_i = 0, rst_n_i = 0, reg_wr_i = 0, reg_rd_i = 0, threshold_i = 0;
  logic run_control_i = 0, halted_flag_i = 1, seen = 0;
  logic [7:0] reg_addr_i = 8'h0;
  logic [31:0] reg_wdata_i = 32'h0, reg_rdata_o;
  logic [1:0] list_size_select_i = 2'h0;
  logic [5:0] status_flags_i = 6'h0;
  logic rollover_set_o, irq_o;
  logic [13:0] microframe_index_o;
  logic [10:0] sof_frame_number_o;
  logic [9:0] list_index_o;
  int err_total = 0, cmp_count = 0, cyc = 0;
  // Rows: enable, status, threshold, expected irq
  logic [13:0] rows [9] = '{14'h411, 14'h821, 14'h1041, 14'h104, 14'h107,
    14'h20B, 14'h2080, 14'h2083, 14'hFE};
  always #5 clk_i = ~clk_i;
  uhie_regs #(.UFRAME_CYCLES(10)) DUT (.*);
  task automatic tk;
    @(posedge clk_i);
    #1;
  endtask
  task automatic chk(logic [31:0] g, logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wr(logic [7:0] ad, logic [31:0] d);
    reg_addr_i = ad;
    reg_wdata_i = d;
    reg_wr_i = 1;
    tk;
    reg_wr_i = 0;
  endtask
  task automatic rd(logic [7:0] ad, logic [31:0] e);
    reg_addr_i = ad;
    reg_rd_i = 1;
    tk;
    reg_rd_i = 0;
    chk(reg_rdata_o, e);
  endtask
  task automatic test_done;
    if (err_total == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (rollover_set_o) seen <= 1;
    if (cyc == 2000) begin
      err_total++;
      test_done;
    end
  end
  initial begin
    repeat (10) tk;
    rst_n_i = 1;
    wr(8'h28, 32'h0000003F);
    rd(8'h28, 32'h3F);
    rd(8'h30, 32'h0);
    foreach (rows[i]) begin
      wr(8'h28, {26'h0, rows[i][13:8]});
      status_flags_i = rows[i][7:2];
      tk;
      threshold_i = rows[i][1];
      tk;
      threshold_i = 0;
      tk;
      chk(irq_o, rows[i][0]);
      status_flags_i = 6'h0;
      repeat (2) tk;
    end
    wr(8'h2C, 32'h3FF8);
    chk(sof_frame_number_o, 32'h7FF);
    for (int s = 0; s < 3; s++) begin
      list_size_select_i = 2'(s);
      #1 chk(list_index_o, 32'h3FF >> s);
    end
    list_size_select_i = 2'h0;
    halted_flag_i = 0;
    run_control_i = 1;
    repeat (84) tk;
    run_control_i = 0;
    chk(seen, 1);
    rd(8'h2C, 32'h0);
    wr(8'h2C, 32'h5);
    chk(microframe_index_o, 32'h0);
    tk;
    halted_flag_i = 1;
    wr(8'h2C, 32'h28);
    chk(sof_frame_number_o, 32'h5);
    rst_n_i = 0;
    tk;
    rst_n_i = 1;
    chk(microframe_index_o, 32'h0);
    test_done;
  end
endmodule
bind uhie_regs uhie_regs_assertions u_chk (.*);
`default_nettype wire
